/* verilog/load_store_access_unit.sv */
// load/store access unit: fetch ordering, lane steering, atomic issue
// assumes a bus that answers each transaction with bus_ack, one at a time
`timescale 1ns/1ps
`default_nettype none
module load_store_access_unit
  import lsu_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic big_endian_pin,
  input wire logic req_valid,
  input wire lsu_pkg::core_req_t req,
  output logic req_ready,
  input wire logic exc_abort,
  input wire logic rev_valid,
  input wire lsu_pkg::rev_op_t rev_op,
  input wire logic [31:0] rev_din,
  output logic [31:0] rev_dout,
  output logic rev_done,
  output logic bus_valid,
  output lsu_pkg::bus_req_t bus_req,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  output logic resp_valid,
  output logic [31:0] resp_data,
  output logic [3:0] resp_index,
  output logic resp_fault,
  output logic resp_abandoned,
  output logic [31:0] instr_word,
  output logic instr_is_32
);

  // ------------------------------------------------------------
  // endian strap
  // ------------------------------------------------------------
  // pin is asynchronous: two stages, then caught at the third edge after
  // reset, once the second stage really holds the pin
  logic be_s1_reg, be_s2_reg, big_endian_reg;
  logic [1:0] be_age_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      be_s1_reg <= 1'b0;
      be_s2_reg <= 1'b0;
      big_endian_reg <= 1'b0;
      be_age_reg <= 2'h0;
    end else begin
      be_s1_reg <= big_endian_pin;
      be_s2_reg <= be_s1_reg;
      if (be_age_reg != 2'h3) begin
        big_endian_reg <= be_s2_reg;
        be_age_reg <= be_age_reg + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // byte reverse
  // ------------------------------------------------------------
  logic [31:0] rev_comb;
  byte_reverse_unit u_rev (
    .op(rev_op),
    .din(rev_din),
    .dout(rev_comb)
  );
  logic [31:0] rev_dout_reg, rev_dout_next;
  logic rev_done_reg, rev_done_next;
  always_comb begin
    rev_dout_next = rev_valid ? rev_comb : rev_dout_reg;
    rev_done_next = rev_valid;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rev_dout_reg <= zero_word;
      rev_done_reg <= 1'b0;
    end else begin
      rev_dout_reg <= rev_dout_next;
      rev_done_reg <= rev_done_next;
    end
  end

  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  // one transaction outstanding at a time keeps every access in program
  // order for all types; costs throughput on Normal memory
  typedef enum logic [1:0] {st_idle, st_issue, st_wait, st_fetch2} state_t;
  state_t state_reg, state_next;
  core_req_t cur_reg, cur_next;
  logic [31:0] addr_reg, addr_next;
  logic [3:0] left_reg, left_next, idx_reg, idx_next;
  logic big_reg, big_next;
  logic bus_valid_reg, bus_valid_next;
  bus_req_t bus_req_reg, bus_req_next;
  logic resp_valid_reg, resp_valid_next, resp_fault_reg, resp_fault_next;
  logic resp_ab_reg, resp_ab_next;
  logic [31:0] resp_data_reg, resp_data_next;
  logic [3:0] resp_idx_reg, resp_idx_next;
  logic [31:0] instr_reg, instr_next;
  logic is32_reg, is32_next, hi_pend_reg, hi_pend_next;
  logic [15:0] half1_reg, half1_next;
  logic req_ready_reg, req_ready_next;

  logic misaligned, in_ppb, use_big;
  logic [3:0] store_byte_c;
  logic [31:0] lane_wdata, load_val;
  logic [1:0] lo;
  logic [7:0] rbyte;
  logic [15:0] rhalf, first_halfword, second_halfword;
  mem_attr_t attr_c;

  always_comb begin
    // word, multi and halfword alignment checks
    unique case (req.op)
      op_load, op_store: begin
        misaligned = (req.size == size_word && req.addr[1:0] != 2'b00) ||
                     (req.size == size_half && req.addr[0]);
      end
      op_load_multiple, op_store_multiple: begin
        misaligned = req.addr[1:0] != 2'b00;
      end
      op_fetch: misaligned = req.addr[0];
      default: misaligned = 1'b1;
    endcase
  end

  always_comb begin
    in_ppb = (cur_reg.addr & ppb_mask) == ppb_base;
    use_big = big_reg && !in_ppb;
    lo = addr_reg[1:0];
    attr_c = cur_reg.attr;
    if (attr_c.mtype == mem_strongly_ordered) begin
      attr_c.shareable = 1'b1;
    end
    if (attr_c.mtype != mem_normal) begin
      attr_c.cclass = cache_none;
    end
    // lanes from element size and low address bits
    store_byte_c = store_byte_all;
    lane_wdata = cur_reg.wdata;
    if (cur_reg.op == op_store) begin
      unique case (cur_reg.size)
        size_byte: begin
          store_byte_c = store_byte_byte << lo;
          lane_wdata = {4{cur_reg.wdata[7:0]}};
        end
        size_half: begin
          store_byte_c = store_byte_half << lo;
          lane_wdata = use_big ?
            {2{cur_reg.wdata[7:0], cur_reg.wdata[15:8]}} :
            {2{cur_reg.wdata[15:0]}};
        end
        default: begin
          lane_wdata = use_big ?
            {cur_reg.wdata[7:0], cur_reg.wdata[15:8],
             cur_reg.wdata[23:16], cur_reg.wdata[31:24]} :
            cur_reg.wdata;
        end
      endcase
    end else if (cur_reg.op == op_store_multiple) begin
      lane_wdata = use_big ?
        {cur_reg.wdata[7:0], cur_reg.wdata[15:8],
         cur_reg.wdata[23:16], cur_reg.wdata[31:24]} : cur_reg.wdata;
    end
    // load extraction
    rbyte = bus_rdata[8*lo +: 8];
    rhalf = lo[1] ? bus_rdata[31:16] : bus_rdata[15:0];
    if (use_big) begin
      rhalf = {rhalf[7:0], rhalf[15:8]};
    end
    unique case (cur_reg.op == op_load ? cur_reg.size : size_word)
      size_byte: load_val = {{24{cur_reg.sign_ext & rbyte[7]}}, rbyte};
      size_half: load_val = {{16{cur_reg.sign_ext & rhalf[15]}}, rhalf};
      default: load_val = use_big ?
        {bus_rdata[7:0], bus_rdata[15:8], bus_rdata[23:16], bus_rdata[31:24]}
        : bus_rdata;
    endcase
    // fetch halves always little-endian, lower address low byte
    first_halfword = lo[1] ? bus_rdata[31:16] : bus_rdata[15:0];
    second_halfword = first_halfword;
  end

  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    addr_next = addr_reg;
    left_next = left_reg;
    idx_next = idx_reg;
    big_next = big_reg;
    bus_valid_next = bus_valid_reg;
    bus_req_next = bus_req_reg;
    resp_valid_next = 1'b0;
    resp_fault_next = resp_fault_reg;
    resp_ab_next = 1'b0;
    resp_data_next = resp_data_reg;
    resp_idx_next = resp_idx_reg;
    instr_next = instr_reg;
    is32_next = is32_reg;
    half1_next = half1_reg;
    hi_pend_next = hi_pend_reg;
    req_ready_next = 1'b0;
    unique case (state_reg)
      st_idle: begin
        req_ready_next = 1'b1;
        if (req_valid && req_ready_reg) begin
          req_ready_next = 1'b0;
          cur_next = req;
          addr_next = req.addr;
          left_next = (req.op == op_load_multiple ||
                       req.op == op_store_multiple) ? req.count : count_one;
          idx_next = 4'h0;
          big_next = big_endian_reg && req.op != op_fetch;
          if (misaligned || left_next == 4'h0) begin
            resp_valid_next = 1'b1;
            resp_fault_next = misaligned;
            resp_data_next = zero_word;
            state_next = st_idle;
          end else begin
            state_next = st_issue;
          end
        end
      end
      st_issue, st_fetch2: begin
        // each beat is one aligned atomic transfer
        bus_valid_next = 1'b1;
        bus_req_next.write = cur_reg.op == op_store ||
                             cur_reg.op == op_store_multiple;
        bus_req_next.addr = {addr_reg[31:2], 2'b00};
        bus_req_next.store_byte = bus_req_next.write ? store_byte_c : store_byte_none;
        bus_req_next.wdata = lane_wdata;
        bus_req_next.attr = attr_c; // device keeps one write
        state_next = st_wait;
      end
      st_wait: begin
        if (bus_ack) begin
          bus_valid_next = 1'b0;
          if (cur_reg.op == op_fetch) begin
            // lower address gives first_halfword
            if (hi_pend_reg) begin
              instr_next = {second_halfword, half1_reg};
              is32_next = 1'b1;
              resp_valid_next = 1'b1;
              resp_fault_next = 1'b0;
              resp_data_next = {second_halfword, half1_reg};
              hi_pend_next = 1'b0;
              state_next = st_idle;
            end else if (first_halfword[15:11] == 5'b11101 ||
                         first_halfword[15:13] == 3'b111 &&
                         first_halfword[12:11] != 2'b00) begin
              // 32-bit instruction needs the next halfword
              half1_next = first_halfword;
              hi_pend_next = 1'b1;
              addr_next = addr_reg + 32'h0000_0002;
              state_next = st_fetch2;
            end else begin
              instr_next = {16'h0000, first_halfword};
              is32_next = 1'b0;
              resp_valid_next = 1'b1;
              resp_fault_next = 1'b0;
              resp_data_next = {16'h0000, first_halfword};
              state_next = st_idle;
            end
          end else begin
            resp_valid_next = 1'b1;
            resp_fault_next = 1'b0;
            resp_data_next = bus_req_reg.write ? zero_word : load_val;
            resp_idx_next = idx_reg;
            idx_next = idx_reg + 4'h1;
            left_next = left_reg - 4'h1;
            addr_next = addr_reg + word_step;
            if (left_reg == count_one) begin
              state_next = st_idle;
            end else if (exc_abort) begin
              // core restarts the whole sequence later
              resp_ab_next = 1'b1;
              state_next = st_idle;
            end else begin
              state_next = st_issue;
            end
          end
        end
      end
      default: state_next = st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= st_idle;
      cur_reg <= '0;
      addr_reg <= zero_word;
      left_reg <= 4'h0;
      idx_reg <= 4'h0;
      big_reg <= 1'b0;
      bus_valid_reg <= 1'b0;
      bus_req_reg <= '0;
      resp_valid_reg <= 1'b0;
      resp_fault_reg <= 1'b0;
      resp_ab_reg <= 1'b0;
      resp_data_reg <= zero_word;
      resp_idx_reg <= 4'h0;
      instr_reg <= zero_word;
      is32_reg <= 1'b0;
      half1_reg <= 16'h0000;
      hi_pend_reg <= 1'b0;
      req_ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      addr_reg <= addr_next;
      left_reg <= left_next;
      idx_reg <= idx_next;
      big_reg <= big_next;
      bus_valid_reg <= bus_valid_next;
      bus_req_reg <= bus_req_next;
      resp_valid_reg <= resp_valid_next;
      resp_fault_reg <= resp_fault_next;
      resp_ab_reg <= resp_ab_next;
      resp_data_reg <= resp_data_next;
      resp_idx_reg <= resp_idx_next;
      instr_reg <= instr_next;
      is32_reg <= is32_next;
      half1_reg <= half1_next;
      hi_pend_reg <= hi_pend_next;
      req_ready_reg <= req_ready_next;
    end
  end

  // no exclusive monitor exists at all
  // no cache here, so fills cannot split a transfer
  assign req_ready = req_ready_reg;
  assign rev_dout = rev_dout_reg;
  assign rev_done = rev_done_reg;
  assign bus_valid = bus_valid_reg;
  assign bus_req = bus_req_reg;
  assign resp_valid = resp_valid_reg;
  assign resp_data = resp_data_reg;
  assign resp_index = resp_idx_reg;
  assign resp_fault = resp_fault_reg;
  assign resp_abandoned = resp_ab_reg;
  assign instr_word = instr_reg;
  assign instr_is_32 = is32_reg;

endmodule
`default_nettype wire

/* shared/lsu_pkg.sv */
// package for the load/store access unit: encodings, types, constants
// assumes one clock domain; the core supplies requests, a bus answers
package lsu_pkg;

  typedef enum logic [1:0] {
    size_byte,
    size_half,
    size_word
  } elem_size_t;

  typedef enum logic [2:0] {
    op_load,
    op_store,
    op_load_multiple,
    op_store_multiple,
    op_fetch
  } access_op_t;

  typedef enum logic [1:0] {
    mem_normal,
    mem_device,
    mem_strongly_ordered
  } mem_type_t;

  typedef enum logic [1:0] {
    cache_none,
    cache_write_through,
    cache_write_back
  } cache_class_t;

  typedef enum logic [1:0] {
    rev_word,
    rev_signed_half,
    rev_packed_halves
  } rev_op_t;

  typedef struct packed {
    mem_type_t mtype;
    logic shareable;
    cache_class_t cclass;
  } mem_attr_t;

  typedef struct packed {
    access_op_t op;
    elem_size_t size;
    logic sign_ext;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] count;
    mem_attr_t attr;
  } core_req_t;

  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [3:0] store_byte;
    logic [31:0] wdata;
    mem_attr_t attr;
  } bus_req_t;

  // private peripheral bus window
  localparam logic [31:0] ppb_base = 32'hE000_0000;
  localparam logic [31:0] ppb_mask = 32'hFFF0_0000;
  localparam logic [31:0] word_step = 32'h0000_0004;
  localparam logic [3:0] count_one = 4'h1;
  localparam logic [3:0] store_byte_all = 4'hF;
  localparam logic [3:0] store_byte_byte = 4'h1;
  localparam logic [3:0] store_byte_half = 4'h3;
  localparam logic [3:0] store_byte_none = 4'h0;
  localparam logic [31:0] zero_word = 32'h0000_0000;

endpackage

/* verilog/byte_reverse_unit.sv */
// byte reverse datapath operations on a register value
// assumes a registered caller; purely combinational
`timescale 1ns/1ps
`default_nettype none
module byte_reverse_unit
  import lsu_pkg::*;
(
  input wire lsu_pkg::rev_op_t op,
  input wire logic [31:0] din,
  output logic [31:0] dout
);
  always_comb begin
    unique case (op)
      rev_word: dout = {din[7:0], din[15:8], din[23:16], din[31:24]};
      rev_signed_half: dout = {{16{din[7]}}, din[7:0], din[15:8]};
      rev_packed_halves: begin
        dout = {din[23:16], din[31:24], din[7:0], din[15:8]};
      end
      default: dout = din;
    endcase
  end
endmodule
`default_nettype wire

/* testbench/bus_memory_model.sv */
// byte-lane memory on the far side of the access unit's bus
// assumes bus_valid and bus_req hold until the edge that samples bus_ack
`timescale 1ns/1ps
`default_nettype none
module bus_memory_model
  import lsu_pkg::*;
(
  input wire logic clk,
  input wire logic bus_valid,
  input wire lsu_pkg::bus_req_t bus_req,
  output logic bus_ack,
  output logic [31:0] bus_rdata
);
  logic [7:0] mem [256];
  logic [7:0] base;
  logic [1:0] wait_cnt;
  integer model_seed = 32'h0000_1de8;
  // ------------------------------
  // answer: 0 to 2 idle cycles, then one ack
  // ------------------------------
  initial begin
    bus_ack = 1'b0;
    bus_rdata = 32'h0000_0000;
    wait_cnt = 2'h0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h00;
  end
  always @(negedge clk) begin
    base = {bus_req.addr[7:2], 2'b00};
    if (bus_valid && !bus_ack && wait_cnt == 2'h0) begin
      bus_ack <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        if (bus_req.write && bus_req.store_byte[i])
          mem[base + 8'(i)] = bus_req.wdata[8*i +: 8];
        bus_rdata[8*i +: 8] <= mem[base + 8'(i)];
      end
    end else begin
      bus_ack <= 1'b0;
      // released data keeps moving so a stale read cannot pass
      bus_rdata <= ~bus_rdata;
      if (bus_ack)
        wait_cnt <= 2'($unsigned($random(model_seed)) % 3);
      else if (bus_valid)
        wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule
`default_nettype wire

/* testbench/lsu_properties.sv */
// assertions on the access unit's ports, bound into its top module
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module lsu_properties
  import lsu_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire lsu_pkg::core_req_t req,
  input wire logic req_ready,
  input wire logic rev_valid,
  input wire lsu_pkg::rev_op_t rev_op,
  input wire logic [31:0] rev_din,
  input wire logic [31:0] rev_dout,
  input wire logic rev_done,
  input wire logic bus_valid,
  input wire lsu_pkg::bus_req_t bus_req,
  input wire logic bus_ack,
  input wire logic resp_valid,
  input wire logic resp_fault
);
  logic [31:0] d;
  logic [31:0] taken;
  logic take;
  // ------------------------------
  // helpers and sequences
  // ------------------------------
  assign take = req_valid && req_ready;
  always_ff @(posedge clk) begin
    d <= rev_din;
    taken <= take ? req.addr : taken;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence word_take(logic ok);
    take && req.op == op_load && req.size == size_word
    && ((req.addr[1:0] == 2'b00) == ok);
  endsequence
  sequence fault_seen;
    ##[0:1] (resp_valid && resp_fault);
  endsequence
  // ------------------------------
  // properties
  // ------------------------------
  done_pulse_a: assert property (rev_valid |=> rev_done)
    else $error("reverse done missing");
  rev_word_a: assert property (
    rev_valid && rev_op == rev_word |=>
    rev_dout == {d[7:0], d[15:8], d[23:16], d[31:24]})
    else $error("word reverse wrong");
  rev_signed_a: assert property (
    rev_valid && rev_op == rev_signed_half |=>
    rev_dout == {{16{d[7]}}, d[7:0], d[15:8]})
    else $error("signed half reverse wrong");
  rev_packed_a: assert property (
    rev_valid && rev_op == rev_packed_halves |=>
    rev_dout == {d[23:16], d[31:24], d[7:0], d[15:8]})
    else $error("packed reverse wrong");
  bus_hold_a: assert property (
    bus_valid && !bus_ack |=> bus_valid && $stable(bus_req))
    else $error("bus request changed before answer");
  read_strobe_a: assert property (
    bus_valid && !bus_req.write |-> bus_req.store_byte == store_byte_none)
    else $error("read carries strobes");
  write_lanes_a: assert property (
    bus_valid && bus_req.write |-> bus_req.addr[1:0] == 2'b00 &&
    bus_req.store_byte inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
    else $error("write strobes not one atomic piece");
  strong_share_a: assert property (
    bus_valid && bus_req.attr.mtype == mem_strongly_ordered
    |-> bus_req.attr.shareable)
    else $error("strongly ordered not shareable");
  cache_class_a: assert property (
    bus_valid && bus_req.attr.mtype != mem_normal
    |-> bus_req.attr.cclass == cache_none)
    else $error("uncached type carries a cache class");
  one_at_once_a: assert property (bus_valid |-> !req_ready)
    else $error("ready while a transaction is open");
  word_issue_a: assert property (word_take(1'b1) |-> ##[2:3] (
    bus_valid && !bus_req.write && bus_req.addr == taken))
    else $error("word load not issued at its address");
  misalign_fault_a: assert property (word_take(1'b0) |=>
    !bus_valid throughout fault_seen)
    else $error("misaligned word not faulted");
  reset_quiet_a: assert property (disable iff (1'b0)
    !nrst |=> !bus_valid && !resp_valid && !req_ready)
    else $error("outputs active after reset");
endmodule
bind load_store_access_unit lsu_properties u_lsu_properties (.clk, .nrst,
  .req_valid, .req, .req_ready, .rev_valid, .rev_op, .rev_din, .rev_dout,
  .rev_done, .bus_valid, .bus_req, .bus_ack, .resp_valid, .resp_fault);
`default_nettype wire

/* testbench/testbench.sv */
// random and corner tests of the access unit against a byte shadow
// assumes the package, design, bus model and checker compile first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lsu_pkg::*;
  logic clk, nrst, big_endian_pin, req_valid, req_ready, exc_abort;
  logic rev_valid, rev_done, bus_valid, bus_ack, resp_valid, resp_fault;
  logic resp_abandoned, instr_is_32, big, g_fault, g_abd, g_is32;
  logic [31:0] rev_din, rev_dout, bus_rdata, resp_data, instr_word;
  logic [31:0] g_data, g_instr, a;
  logic [3:0] resp_index, g_index;
  core_req_t req;
  bus_req_t bus_req;
  rev_op_t rev_op;
  elem_size_t s;
  access_op_t op;
  access_op_t ops [3] = '{op_load, op_store, op_load_multiple};
  logic [7:0] sh [256];
  integer seed = 32'h0000_1de8;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  load_store_access_unit u_load_store_access_unit (.clk, .nrst,
    .big_endian_pin, .req_valid, .req, .req_ready, .exc_abort, .rev_valid,
    .rev_op, .rev_din, .rev_dout, .rev_done, .bus_valid, .bus_req,
    .bus_ack, .bus_rdata, .resp_valid, .resp_data, .resp_index,
    .resp_fault, .resp_abandoned, .instr_word, .instr_is_32);
  bus_memory_model u_bus_memory_model (.clk, .bus_valid, .bus_req,
    .bus_ack, .bus_rdata);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      wrap_up();
    end
  end
  // ------------------------------
  // expectations and checks
  // ------------------------------
  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction
  function automatic logic le_for(logic [31:0] x);
    return !big || ((x & ppb_mask) == ppb_base);
  endfunction
  function automatic logic [31:0] sh_rd(logic [31:0] x, int n, logic le);
    logic [31:0] v;
    v = zero_word;
    for (int i = 0; i < n; i++)
      v[8*(le ? i : n-1-i) +: 8] = sh[8'(x + 32'(i))];
    return v;
  endfunction
  function automatic logic [31:0] exp_ld(logic [31:0] x, elem_size_t z,
                                         logic sx);
    logic [31:0] v;
    v = sh_rd(x, 1 << int'(z), le_for(x));
    if (sx && z == size_byte)
      v[31:8] = {24{v[7]}};
    if (sx && z == size_half)
      v[31:16] = {16{v[15]}};
    return v;
  endfunction
  function automatic logic [31:0] exp_rev(rev_op_t o, logic [31:0] x);
    case (o)
      rev_word: return {x[7:0], x[15:8], x[23:16], x[31:24]};
      rev_signed_half: return {{16{x[7]}}, x[7:0], x[15:8]};
      default: return {x[23:16], x[31:24], x[7:0], x[15:8]};
    endcase
  endfunction
  task automatic chk32(logic [31:0] got, logic [31:0] want);
    check_count++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk1(logic got, logic want);
    chk32({31'h0, got}, {31'h0, want});
  endtask
  // ------------------------------
  // drivers
  // ------------------------------
  task automatic issue(access_op_t o, elem_size_t z, logic sx,
                       logic [31:0] x, logic [31:0] wd, logic [3:0] n);
    int t;
    t = 0;
    while (req_ready !== 1'b1 && t < 300) begin
      @(negedge clk);
      t++;
    end
    req = '{o, z, sx, x, wd, n, '{mem_type_t'(rnd() % 3),
      rnd() % 2 != 0, cache_class_t'(rnd() % 3)}};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic await_resp();
    int t;
    t = 0;
    while (resp_valid !== 1'b1 && t < 300) begin
      @(negedge clk);
      t++;
    end
    chk1(resp_valid, 1'b1);
    {g_data, g_index, g_fault, g_abd} =
      {resp_data, resp_index, resp_fault, resp_abandoned};
    {g_instr, g_is32} = {instr_word, instr_is_32};
    @(negedge clk);
  endtask
  task automatic access(access_op_t o, elem_size_t z, logic sx,
                        logic [31:0] x, logic [31:0] wd);
    logic bad;
    bad = (z == size_half && x[0]) || (z == size_word && x[1:0] != 2'b00);
    issue(o, z, sx, x, wd, count_one);
    await_resp();
    chk1(g_fault, bad);
    if (!bad && o != op_store)
      chk32(g_data, exp_ld(x, z, sx));
    for (int i = 0; i < (bad || o != op_store ? 0 : 1 << int'(z)); i++)
      sh[8'(x + 32'(i))] = wd[8*(le_for(x) ? i : (1<<int'(z))-1-i) +: 8];
  endtask
  task automatic multi(logic [31:0] x, int n, logic abort);
    exc_abort = abort;
    issue(op_load_multiple, size_word, 1'b0, x, zero_word, 4'(n));
    for (int i = 0; i < n && !(abort && i > 0); i++) begin
      await_resp();
      chk32(g_data, exp_ld(x + 32'(4*i), size_word, 1'b0));
      chk32(32'(g_index), 32'(i));
      chk1(g_abd, abort);
    end
    exc_abort = 1'b0;
  endtask
  task automatic fetch(logic [31:0] x);
    logic [15:0] h1, h2;
    logic is32;
    h1 = 16'(sh_rd(x, 2, 1'b1));
    h2 = 16'(sh_rd(x + 32'h0000_0002, 2, 1'b1));
    is32 = h1[15:11] inside {5'b11101, 5'b11110, 5'b11111};
    issue(op_fetch, size_half, 1'b0, x, zero_word, count_one);
    await_resp();
    chk1(g_is32, is32);
    chk32(g_instr, is32 ? {h2, h1} : {16'h0000, h1});
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------
  // main sequence, once per data endianness
  // ------------------------------
  initial begin
    {nrst, big_endian_pin, req_valid, exc_abort, rev_valid, big} = 6'h00;
    {req, rev_din, a} = '0;
    rev_op = rev_word;
    for (int i = 0; i < 256; i++)
      sh[i] = 8'h00;
    for (int e = 0; e < 2; e++) begin
      @(negedge clk);
      nrst = 1'b0;
      big_endian_pin = e[0];
      big = e[0];
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      // strap is caught once; a later change must not matter
      big_endian_pin = ~e[0];
      for (int p = 0; p < 2; p++) begin
        a = (p == 0) ? 32'h0000_1040 : (ppb_base | 32'h0000_0040);
        access(op_store, size_word, 1'b0, a, 32'h8899_aabb);
        for (int k = 0; k < 4; k++)
          access(op_load, elem_size_t'(k % 2), 1'b1, a + 32'(k), 0);
      end
      repeat (60) begin
        s = elem_size_t'(rnd() % 3);
        op = ops[rnd() % 3];
        if (op == op_load_multiple)
          s = size_word;
        a = ((rnd() % 2 != 0) ? ppb_base : 32'h0000_1000) | (rnd() & 32'hFF);
        if (rnd() % 4 != 0)
          a = a & ~((32'h1 << int'(s)) - 32'h1);
        access(op, s, rnd() % 2 != 0, a, rnd());
      end
      for (int k = 0; k < 8; k++) begin
        a = 32'h0000_1000 | (rnd() & 32'hFE);
        access(op_store, size_byte, 1'b0, a + 32'h1,
               k[0] ? (rnd() % 128) : (32'hE8 + rnd() % 24));
        fetch(a);
      end
      multi(32'h0000_1080, 3, 1'b0);
      multi(32'h0000_10C0, 4, 1'b1);
      multi(32'h0000_10C0, 4, 1'b0);
      issue(op_store_multiple, size_word, 1'b0, 32'h0000_1080,
            32'h1357_9bdf, 4'h2);
      for (int i = 0; i < 2; i++) begin
        await_resp();
        chk32(32'(g_index), 32'(i));
      end
      for (int i = 0; i < 8; i++)
        sh[8'(32'h80 + 32'(i))] =
          8'(32'h1357_9bdf >> (big ? 24 - 8 * (i % 4) : 8 * (i % 4)));
      multi(32'h0000_1080, 3, 1'b0);
      issue(op_fetch, size_half, 1'b0, 32'h0000_1001, zero_word, count_one);
      await_resp();
      chk1(g_fault, 1'b1);
      issue(op_load_multiple, size_word, 1'b0, 32'h0000_1080, 0, 4'h0);
      await_resp();
      chk1(g_fault, 1'b0);
      for (int o = 0; o < 3; o++) begin
        for (int k = 0; k < 4; k++) begin
          rev_op = rev_op_t'(o);
          rev_din = (k == 0) ? 32'h1234_5680 : rnd();
          rev_valid = 1'b1;
          @(negedge clk);
          rev_valid = 1'b0;
          chk1(rev_done, 1'b1);
          chk32(rev_dout, exp_rev(rev_op, rev_din));
          @(negedge clk);
        end
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire
